// ---- inc/irq_ctrl_pkg.sv ----
/*
 Package for the four-source vectored interrupt controller: register
 offsets, field positions, vectors and carrier types.
 Assumes an 8-bit data memory bus and an 11-bit program counter.
*/
package irq_ctrl_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] PRI_ADDR = 8'h0B;
   localparam logic [7:0] SEC_ADDR = 8'h1E;
   localparam logic [7:0] PRI_RESET = 8'h00;
   localparam logic [7:0] SEC_RESET = 8'h00;
   // ==========================================================
   // Primary register fields
   localparam int PRI_MASTER_BIT = 0;
   localparam int PRI_EXT_EN_BIT = 1;
   localparam int PRI_TB_EN_BIT = 2;
   localparam int PRI_RTC_EN_BIT = 3;
   localparam int PRI_EXT_FLAG_BIT = 4;
   localparam int PRI_TB_FLAG_BIT = 5;
   localparam int PRI_RTC_FLAG_BIT = 6;
   // ==========================================================
   // Secondary register fields
   localparam int SEC_TMR_EN_BIT = 0;
   localparam int SEC_TMR_FLAG_BIT = 4;
   // ==========================================================
   // Vectors
   localparam logic [10:0] VEC_EXT = 11'h004;
   localparam logic [10:0] VEC_TB = 11'h008;
   localparam logic [10:0] VEC_RTC = 11'h00C;
   localparam logic [10:0] VEC_TMR = 11'h010;
   // ==========================================================
   // Stack
   localparam int STACK_LEVELS = 4;
   localparam int PC_W = 11;
   // Source index order is also priority order, 0 highest
   localparam int SRC_EXT = 0;
   localparam int SRC_TB = 1;
   localparam int SRC_RTC = 2;
   localparam int SRC_TMR = 3;

   // Data memory access carrier
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_acc_t;

   // Call request toward the sequencer
   typedef struct packed {
      logic valid;
      logic [10:0] vector;
   } call_req_t;
endpackage

// ---- src/irq_ret_stack.sv ----
/*
 Four-level return address stack with its pointer.
 Assumes one push or pop per cycle from the sequencer; push wins if both.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_ret_stack
   import irq_ctrl_pkg::*;
#(
   parameter int LEVELS = STACK_LEVELS
) (
   input wire logic clk,           // System clock
   input wire logic resetn,        // Async reset, low
   input wire logic push,          // Save address
   input wire logic pop,           // Restore address
   input wire logic [PC_W-1:0] push_pc, // Address saved
   output logic [PC_W-1:0] top_pc, // Most recent entry
   output logic full               // All levels taken
);
   logic [PC_W-1:0] mem_r [LEVELS];
   logic [2:0] depth_r;
   logic [1:0] wp_r;

   // ==========================================================
   // Pointer; an overfull push wraps and loses the oldest entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         depth_r <= 3'h0;
         wp_r <= 2'h0;
      end else if (push) begin
         wp_r <= wp_r + 2'h1;
         if (depth_r != 3'(LEVELS)) begin
            depth_r <= depth_r + 3'h1;
         end
      end else if (pop && depth_r != 3'h0) begin
         wp_r <= wp_r - 2'h1;
         depth_r <= depth_r - 3'h1;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= push_pc;
      end
   end

   assign top_pc = mem_r[wp_r - 2'h1];
   assign full = (depth_r == 3'(LEVELS));
endmodule
`default_nettype wire

// ---- src/irq_ctrl.sv ----
/*
 Vectored interrupt controller with four sources, its control registers
 and the return address stack.
 Assumes the sequencer pulses instruction strobes for one cycle and
 takes a call request only on a phase two pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl
   import irq_ctrl_pkg::*;
(
   input wire logic CLK,              // 25 MHz clock
   input wire logic RESETN,           // Async reset, low
   input wire logic EXT_IRQ_N,        // External pin, active low
   input wire logic TMRA_OVF,         // Timer A overflow pulse
   input wire logic TMRB_OVF,         // Timer B overflow pulse
   input wire logic TB_TICK,          // Time base tick pulse
   input wire logic RTC_TICK,         // RTC tick pulse
   input wire logic PHASE_TWO_PULSE,  // Second phase strobe
   input wire mem_acc_t MEM,          // Data memory access
   input wire logic CALL_OP,          // Subroutine call pulse
   input wire logic SUB_RETURN_OP,    // Plain return pulse
   input wire logic ISR_RETURN_OP,    // Interrupt return pulse
   input wire logic HALT_OP,          // Halt entry pulse
   input wire logic [PC_W-1:0] PC,    // Current program counter
   output call_req_t CALL_REQ,        // Vector call pulse
   output logic [PC_W-1:0] RET_PC,    // Return address
   output logic [7:0] RDATA,          // Register read data
   output logic HALTED,               // Halt mode state
   output logic WAKE,                 // Wake pulse
   output logic STACK_FULL            // Stack fully occupied
);
   // ==========================================================
   // Declarations
   logic [2:0] ext_sync_r;
   logic ext_prev_r;
   logic ext_fall;
   logic master_r;
   logic [3:0] en_r;
   logic [3:0] flag_r;
   logic [3:0] flag_nxt;
   logic [3:0] hw_set;
   logic [3:0] halt_mask_r;
   logic [3:0] pend;
   logic [3:0] grant;
   logic ack;
   logic push;
   logic pop;
   logic full;
   logic [PC_W-1:0] top_pc;
   logic wr_pri;
   logic wr_sec;

   // Assertion clock and reset; one domain, so one default
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   // One-hot highest priority pick, index 0 first
   function automatic logic [3:0] pick(input logic [3:0] req);
      logic [3:0] g;
      g = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (req[i]) begin
            g = 4'h0;
            g[i] = 1'b1;
         end
      end
      return g;
   endfunction

   function automatic logic [PC_W-1:0] vec_of(input logic [3:0] g);
      logic [PC_W-1:0] v;
      v = VEC_TMR;
      if (g[SRC_EXT]) v = VEC_EXT;
      else if (g[SRC_TB]) v = VEC_TB;
      else if (g[SRC_RTC]) v = VEC_RTC;
      return v;
   endfunction

   // ==========================================================
   // External pin synchroniser; stage 0 feeds only stage 1
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ext_sync_r <= 3'h7;
         ext_prev_r <= 1'b1;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], EXT_IRQ_N};
         if (ext_sync_r[1] == ext_sync_r[2]) begin
            ext_prev_r <= ext_sync_r[2];
         end
      end
   end
   assign ext_fall = ext_prev_r && !ext_sync_r[2] && !ext_sync_r[1];

   // ==========================================================
   // Decode and arbitration
   assign wr_pri = MEM.wr && (MEM.addr == PRI_ADDR);
   assign wr_sec = MEM.wr && (MEM.addr == SEC_ADDR);
   assign hw_set[SRC_EXT] = ext_fall;
   assign hw_set[SRC_TB] = TB_TICK;
   assign hw_set[SRC_RTC] = RTC_TICK;
   assign hw_set[SRC_TMR] = TMRA_OVF | TMRB_OVF;
   // Master gate blocks all while a handler runs
   assign pend = flag_r & en_r & {4{master_r}};
   assign grant = pick(pend);
   // Sampled on phase two; a full stack holds it off until a pop
   assign ack = PHASE_TWO_PULSE && (pend != 4'h0) && !full && !HALTED;
   assign push = ack || CALL_OP;
   assign pop = SUB_RETURN_OP || ISR_RETURN_OP;

   // ==========================================================
   // Request flags: software write, then ack clear, then hardware set
   always_comb begin
      flag_nxt = flag_r;
      if (wr_pri) begin
         flag_nxt[SRC_EXT] = MEM.wdata[PRI_EXT_FLAG_BIT];
         flag_nxt[SRC_TB] = MEM.wdata[PRI_TB_FLAG_BIT];
         flag_nxt[SRC_RTC] = MEM.wdata[PRI_RTC_FLAG_BIT];
      end
      if (wr_sec) begin
         flag_nxt[SRC_TMR] = MEM.wdata[SEC_TMR_FLAG_BIT];
      end
      if (ack) begin
         flag_nxt = flag_nxt & ~grant;
      end
      flag_nxt = flag_nxt | hw_set;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         flag_r <= 4'h0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // ==========================================================
   // Enables; ack clear outranks a same-cycle write to the master bit
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         master_r <= PRI_RESET[PRI_MASTER_BIT];
         en_r <= 4'h0;
      end else begin
         if (wr_pri) begin
            master_r <= MEM.wdata[PRI_MASTER_BIT];
            en_r[SRC_EXT] <= MEM.wdata[PRI_EXT_EN_BIT];
            en_r[SRC_TB] <= MEM.wdata[PRI_TB_EN_BIT];
            en_r[SRC_RTC] <= MEM.wdata[PRI_RTC_EN_BIT];
         end
         if (wr_sec) begin
            en_r[SRC_TMR] <= MEM.wdata[SEC_TMR_EN_BIT];
         end
         if (ISR_RETURN_OP) begin
            master_r <= 1'b1;
         end
         if (ack) begin
            master_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Halt and wake; flags already up at entry cannot wake
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HALTED <= 1'b0;
         WAKE <= 1'b0;
         halt_mask_r <= 4'h0;
      end else begin
         WAKE <= 1'b0;
         if (HALT_OP && !HALTED) begin
            HALTED <= 1'b1;
            halt_mask_r <= flag_r;
         end else if (HALTED && ((flag_r & ~halt_mask_r) != 4'h0)) begin
            HALTED <= 1'b0;
            WAKE <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs, all registered
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CALL_REQ <= '0;
         RET_PC <= '0;
         STACK_FULL <= 1'b0;
      end else begin
         CALL_REQ.valid <= ack;
         CALL_REQ.vector <= ack ? vec_of(grant) : CALL_REQ.vector;
         RET_PC <= top_pc;
         STACK_FULL <= full;
      end
   end

   // Read data: unused bits are zero
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
      end else if (MEM.addr == PRI_ADDR) begin
         RDATA <= {1'b0, flag_r[SRC_RTC], flag_r[SRC_TB], flag_r[SRC_EXT],
                   en_r[SRC_RTC], en_r[SRC_TB], en_r[SRC_EXT],
                   master_r};
      end else if (MEM.addr == SEC_ADDR) begin
         RDATA <= {3'h0, flag_r[SRC_TMR], 3'h0, en_r[SRC_TMR]};
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ==========================================================
   // Return address stack, program counter only
   irq_ret_stack #(.LEVELS(STACK_LEVELS)) u_stack (
      .clk(CLK),
      .resetn(RESETN),
      .push(push),
      .pop(pop),
      .push_pc(PC),
      .top_pc(top_pc),
      .full(full)
   );

   // ==========================================================
   // Checks: acknowledge and master enable
   AST_ACK_CLEARS_MASTER: assert property (
      ack |=> !master_r)
      else $error("master enable not cleared");
   AST_NO_ACK_FULL: assert property (
      full |-> !ack)
      else $error("ack with full stack");
   AST_NO_ACK_MASKED: assert property (
      !master_r |-> !ack)
      else $error("ack while masked");
   AST_ONLY_PHASE2: assert property (
      CALL_REQ.valid |-> $past(PHASE_TWO_PULSE))
      else $error("off phase");
   AST_ACK_READY: assert property (
      PHASE_TWO_PULSE && pend != 4'h0 && !full && !HALTED |-> ack)
      else $error("ready request not taken");
   AST_VALID_ONE: assert property (
      CALL_REQ.valid |=> !CALL_REQ.valid)
      else $error("call request held");
   AST_NEST_REARM: assert property (
      wr_pri && MEM.wdata[PRI_MASTER_BIT] && !ack |=> master_r)
      else $error("master enable not rearmed");
   AST_ISR_RETURN_OP_SETS: assert property (
      ISR_RETURN_OP && !ack |=> master_r)
      else $error("return no enable");
   AST_RET_KEEPS: assert property (
      SUB_RETURN_OP && !ISR_RETURN_OP && !ack && !wr_pri
      |=> master_r == $past(master_r))
      else $error("plain return altered");
   // Checks: vectors, priority and the saved address
   AST_EXT_VECTOR: assert property (
      ack && grant[SRC_EXT] |=> CALL_REQ.vector == VEC_EXT)
      else $error("bad ext vector");
   AST_TB_VECTOR: assert property (
      ack && grant[SRC_TB] |=> CALL_REQ.vector == VEC_TB)
      else $error("bad time base vector");
   AST_RTC_VECTOR: assert property (
      ack && grant[SRC_RTC] |=> CALL_REQ.vector == VEC_RTC)
      else $error("bad rtc vector");
   AST_TMR_VECTOR: assert property (
      ack && grant[SRC_TMR] |=> CALL_REQ.vector == VEC_TMR)
      else $error("bad timer vector");
   AST_TMR_LAST: assert property (
      ack && grant[SRC_TMR] |-> pend[2:0] == 3'h0)
      else $error("timer beat higher");
   AST_GRANT_ONEHOT: assert property (
      ack |-> $onehot(grant))
      else $error("grant not one hot");
   AST_EXT_FIRST: assert property (
      ack && pend[SRC_EXT] |-> grant[SRC_EXT])
      else $error("external not first");
   AST_TB_SECOND: assert property (
      ack && pend[SRC_TB] && !pend[SRC_EXT] |-> grant[SRC_TB])
      else $error("time base not second");
   AST_PUSH_PC: assert property (
      ack |-> ##2 RET_PC == $past(PC, 2))
      else $error("pushed address wrong");
   // Checks: request flags
   AST_EXT_SETS: assert property (
      ext_fall |=> flag_r[SRC_EXT])
      else $error("external edge lost");
   AST_TMR_SETS: assert property (
      TMRA_OVF || TMRB_OVF |=> flag_r[SRC_TMR])
      else $error("overflow lost");
   AST_TB_SETS_MASKED: assert property (
      TB_TICK && !master_r |=> flag_r[SRC_TB])
      else $error("masked tick lost");
   AST_RTC_SETS: assert property (
      RTC_TICK |=> flag_r[SRC_RTC])
      else $error("rtc tick lost");
   AST_SET_WINS: assert property (
      hw_set[SRC_TB] |=> flag_r[SRC_TB])
      else $error("tick lost");
   AST_EXT_CLEAR: assert property (
      ack && grant[SRC_EXT] && !ext_fall |=> !flag_r[SRC_EXT])
      else $error("external flag kept");
   AST_TB_CLEAR: assert property (
      ack && grant[SRC_TB] && !TB_TICK |=> !flag_r[SRC_TB])
      else $error("time base flag kept");
   AST_RTC_CLEAR: assert property (
      ack && grant[SRC_RTC] && !RTC_TICK |=> !flag_r[SRC_RTC])
      else $error("rtc flag kept");
   AST_TMR_CLEAR: assert property (
      ack && grant[SRC_TMR] && !hw_set[SRC_TMR] |=> !flag_r[SRC_TMR])
      else $error("timer flag kept");
   AST_FLAG_HOLDS: assert property (
      flag_r[SRC_RTC] && !wr_pri && !ack |=> flag_r[SRC_RTC])
      else $error("flag dropped");
   // Checks: halt and registers
   AST_WAKE_NEW: assert property (
      HALTED && (flag_r & ~halt_mask_r) != 4'h0 |=> WAKE && !HALTED)
      else $error("no wake on new flag");
   AST_NO_WAKE_OLD: assert property (
      HALTED && (flag_r & ~halt_mask_r) == 4'h0 |=> !WAKE)
      else $error("wake on old flag");
   AST_RD_BIT7: assert property (
      !RDATA[7])
      else $error("bit 7 set");
   AST_PRI_EN_WR: assert property (
      wr_pri |=> en_r[SRC_RTC] == $past(MEM.wdata[PRI_RTC_EN_BIT]))
      else $error("primary enable not written");
   AST_SEC_EN_WR: assert property (
      wr_sec |=> en_r[SRC_TMR] == $past(MEM.wdata[SEC_TMR_EN_BIT]))
      else $error("secondary enable not written");
   AST_SEC_ZERO: assert property (
      MEM.addr == SEC_ADDR |=> (RDATA & 8'hEE) == 8'h00)
      else $error("secondary spare bits set");
endmodule
`default_nettype wire

// ---- sim/irq_seq_model.sv ----
/*
 Sequencer timing model: makes the second phase strobe of each
 machine cycle. Assumes one clock and an active low async reset.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_seq_model (
   input wire logic clk,         // System clock
   input wire logic resetn,      // Async reset, low
   input wire logic slow,        // Stretch the machine cycle
   output logic phase_two_pulse  // Second phase strobe
);
   // ==========================================================
   // Phase counter
   logic [2:0] ph_r;
   // Free running, so the strobe keeps coming during halt too
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ph_r <= 3'h0;
      end else begin
         ph_r <= ph_r + 3'h1;
      end
   end
   // One strobe per four or eight phases; no calls from handlers
   assign phase_two_pulse = slow ? (ph_r == 3'h1) : (ph_r[1:0] == 2'h1);
endmodule
`default_nettype wire

// ---- sim/irq_ctrl_tb.sv ----
/*
 Self-checking bench for the interrupt controller, with a register
 and stack model. Assumes the sequencer model is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
   miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, \
   g, e); end end
module irq_ctrl_tb
   import irq_ctrl_pkg::*;
();
   // ==========================================================
   // Signals and model state
   logic clk = 1'b0, resetn = 1'b0, ext_n, tmra, tmrb, tbt, rtct, slow;
   logic call_op, sret, iret, halt, p2, halted, wake, sfull;
   logic [PC_W-1:0] pc, ret_pc;
   logic [7:0] rdata;
   mem_acc_t mem;
   call_req_t req;
   int miscompares = 0, tests_run = 0, cyc = 0, wakes = 0;
   int vecs[4] = '{4, 8, 12, 16};
   int stk[$];
   logic [3:0] flg, en;
   logic mst;

   irq_ctrl u_irq_ctrl (
      .CLK(clk), .RESETN(resetn), .EXT_IRQ_N(ext_n), .TMRA_OVF(tmra),
      .TMRB_OVF(tmrb), .TB_TICK(tbt), .RTC_TICK(rtct),
      .PHASE_TWO_PULSE(p2), .MEM(mem), .CALL_OP(call_op),
      .SUB_RETURN_OP(sret), .ISR_RETURN_OP(iret), .HALT_OP(halt),
      .PC(pc), .CALL_REQ(req), .RET_PC(ret_pc), .RDATA(rdata),
      .HALTED(halted), .WAKE(wake), .STACK_FULL(sfull)
   );
   irq_seq_model u_irq_seq_model (
      .clk(clk), .resetn(resetn), .slow(slow), .phase_two_pulse(p2)
   );

   // Clock, hang guard and wake counter
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (wake === 1'b1) begin
         wakes++;
      end
      if (cyc == 4000) begin
         miscompares++;
         summarize();
      end
   end

   // ==========================================================
   // Model views of the two registers
   function automatic logic [7:0] pri_exp();
      return {1'b0, flg[2:0], en[2:0], mst};
   endfunction
   function automatic logic [7:0] sec_exp();
      return {3'h0, flg[3], 3'h0, en[3]};
   endfunction

   // ==========================================================
   // Bus and event tasks
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic rst();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      {flg, en, mst} = 9'h000;
      stk.delete();
      wakes = 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      mem <= '{1'b1, a, d};
      @(posedge clk);
      mem.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      mem <= '{1'b0, a, 8'h00};
      @(posedge clk);
      #1;
      `CHK(rdata, e)
   endtask
   task automatic rd_all();
      rd(PRI_ADDR, pri_exp());
      rd(SEC_ADDR, sec_exp());
   endtask
   // Primary last, so an ack it unlocks is not missed by the poll
   task automatic wr_model();
      pc <= PC_W'($urandom);
      wr(SEC_ADDR, sec_exp());
      wr(PRI_ADDR, pri_exp());
   endtask
   task automatic fire(input int i);
      @(posedge clk);
      case (i)
         0: ext_n <= 1'b0;
         1: tbt <= 1'b1;
         2: rtct <= 1'b1;
         3: tmra <= 1'b1;
         default: tmrb <= 1'b1;
      endcase
      @(posedge clk);
      {tbt, rtct, tmra, tmrb} <= 4'h0;
      repeat (6) @(posedge clk);
      ext_n <= 1'b1;
      flg[(i > 3) ? 3 : i] = 1'b1;
   endtask
   task automatic op(input int k);
      @(posedge clk);
      {call_op, sret, iret, halt} <= 4'(4'h8 >> k);
      @(posedge clk);
      {call_op, sret, iret, halt} <= 4'h0;
   endtask
   task automatic svc(input int i);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (req.valid !== 1'b1 && n < 40);
      `CHK(req.vector, PC_W'(vecs[i]))
      stk.push_back(int'(pc));
      flg[i] = 1'b0;
      mst = 1'b0;
      @(posedge clk);
      #1;
      `CHK(ret_pc, PC_W'(stk[$]))
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {ext_n, tmra, tmrb, tbt, rtct, slow} = 6'h20;
      {call_op, sret, iret, halt} = 4'h0;
      mem = '0;
      pc = '0;
      void'($urandom(32'h38741CDF));
      rst();
      // Reset values, reserved bits and an unmapped address
      rd_all();
      wr(PRI_ADDR, 8'h8F);
      wr(SEC_ADDR, 8'hEF);
      wr(8'h40, 8'hFF);
      {en, mst} = 5'h1F;
      rd_all();
      rd(8'h40, 8'h00);
      {en, mst} = 5'h00;
      wr_model();
      // Each source alone: flag, ack, vector, return
      for (int i = 0; i < 4; i++) begin
         fire(i);
         rd_all();
         en[i] = 1'b1;
         mst = 1'b1;
         wr_model();
         svc(i);
         rd_all();
         op(2);
         mst = 1'b1;
         void'(stk.pop_back());
         rd_all();
         en[i] = 1'b0;
         mst = 1'b0;
         wr_model();
      end
      // All four pending, slow sequencer, served in fixed order
      slow <= 1'b1;
      en = 4'hF;
      wr_model();
      for (int i = 0; i < 5; i++) begin
         fire(i);
      end
      mst = 1'b1;
      wr_model();
      for (int i = 0; i < 4; i++) begin
         svc(i);
         op(2);
         mst = 1'b1;
      end
      // Hardware set beats a software clear in the same cycle
      @(posedge clk);
      mem <= '{1'b1, PRI_ADDR, 8'h00};
      tbt <= 1'b1;
      @(posedge clk);
      mem.wr <= 1'b0;
      tbt <= 1'b0;
      {en, mst} = 5'h10;
      flg = 4'h2;
      rd_all();
      // Nesting: handler reopens master and a second source
      fire(2);
      en = 4'h4;
      mst = 1'b1;
      wr_model();
      svc(2);
      en = 4'h6;
      mst = 1'b1;
      wr_model();
      svc(1);
      // Full stack holds the ack until a plain return
      rst();
      for (int i = 0; i < 4; i++) begin
         pc <= PC_W'($urandom);
         op(0);
         stk.push_back(int'(pc));
         @(posedge clk);
         #1;
         `CHK(sfull, 1'(i == 3))
      end
      en = 4'h2;
      mst = 1'b1;
      wr_model();
      fire(1);
      repeat (8) @(posedge clk);
      rd_all();
      `CHK(ret_pc, PC_W'(stk[3]))
      op(1);
      void'(stk.pop_back());
      svc(1);
      // Halt: a preset flag does not wake, a new source does
      rst();
      fire(2);
      op(3);
      #1;
      `CHK(halted, 1'b1)
      fire(2);
      `CHK(wakes, 0)
      fire(3);
      `CHK(wakes, 1)
      `CHK(halted, 1'b0)
      rd_all();
      summarize();
   end
endmodule
`default_nettype wire
